// *** rtl/aal_cycle_calc.sv ***
// Cycle-count calculator for the add/logic group.
// Assumes the placement fields are stable while the instruction executes.
`timescale 1ns/1ps
module aal_cycle_calc
   import aal_pkg::*;
(
   input  wire aal_timing_s       tim_i,
   output logic [CYC_W-1:0]       cycles_o
);
   wire logic code_ext = (tim_i.code_loc == AAL_LOC_EXT);
   wire logic opnd_ext = (tim_i.opnd_loc == AAL_LOC_EXT);
   wire logic sa_hit   = tim_i.same_block && (tim_i.code_loc == AAL_LOC_SINGLE_ACCESS_RAM)
                         && (tim_i.opnd_loc == AAL_LOC_SINGLE_ACCESS_RAM);
   wire logic [CYC_W-1:0] p  = {12'h000, tim_i.wait_p};
   wire logic [CYC_W-1:0] d  = {12'h000, tim_i.wait_d};
   wire logic [CYC_W-1:0] n  = {8'h00, tim_i.rpt_n};
   // Both factors widened first so the product keeps every bit up to 255 * 15
   wire logic [CYC_W-1:0] nd = {8'h00, tim_i.rpt_n} * {12'h000, tim_i.wait_d};

   wire logic [CYC_W-1:0] single_mem =
      (code_ext && opnd_ext) ? CYC_W'(16'h0002 + d + p) :
      opnd_ext ? CYC_W'(16'h0001 + d) :
      code_ext ? CYC_W'(16'h0001 + p) :
      sa_hit   ? 16'h0002 : 16'h0001;
   wire logic [CYC_W-1:0] rpt_mem =
      (code_ext && opnd_ext) ? CYC_W'(n + 16'h0001 + p + nd) :
      opnd_ext ? CYC_W'(n + nd) :
      code_ext ? CYC_W'(n + p) :
      sa_hit   ? CYC_W'(n + 16'h0001) : n;

   always_comb begin
      unique case (tim_i.form)
         AAL_FORM_SHORT: cycles_o = code_ext ? CYC_W'(16'h0001 + p) : 16'h0001;
         AAL_FORM_LONG:  cycles_o = code_ext ? CYC_W'(16'h0002 + (p << 1)) : 16'h0002;
         default:        cycles_o = tim_i.repeated ? rpt_mem : single_mem;
      endcase
   end
endmodule : aal_cycle_calc

// *** rtl/aal_datapath.sv ***
// Execution datapath: add with carry, unsigned add, shifted add, AND, aux add-immediate.
// Assumes the instruction word and its data operand are presented together with valid.
`timescale 1ns/1ps
module aal_datapath
   import aal_pkg::*;
(
   input  wire logic              mclk_i,
   input  wire logic              reset_n_i,
   input  wire logic              ce_i,
   input  wire logic              instr_valid_i,
   input  wire logic [15:0]       instr_i,
   input  wire logic [15:0]       data_i,
   input  wire logic [15:0]       temp_multiplier_reg_i,
   input  wire logic              sign_extend_mode_i,
   input  wire logic              overflow_mode_i,
   input  wire aal_timing_s       timing_i,
   output logic [31:0]            acc_o,
   output logic                   carry_o,
   output logic                   arith_excess_flag_o,
   output logic [2:0]             aux_pointer_sel_o,
   output logic [15:0]            aux_reg_o,
   output aal_addr_s              addr_o,
   output logic [CYC_W-1:0]       cycles_o,
   output logic                   done_o,
   output logic                   busy_o
);
   typedef enum logic {AAL_IDLE, AAL_WAIT} aal_state_e;

   aal_state_e        state_r;
   logic [31:0]       acc_r;
   logic              carry_r;
   logic              ovf_r;
   logic [2:0]        aux_pointer_sel_r;
   logic [15:0]       aux_r [8];
   aal_addr_s         addr_r;
   logic [CYC_W-1:0]  cycles_r;
   logic [CYC_W-1:0]  cnt_r;
   logic              done_r;
   logic [31:0]       acc_nxt;
   logic              carry_nxt;
   logic              ovf_set;

   wire logic [7:0] opc     = instr_i[15:8];
   wire logic       is_ind  = instr_i[IND_BIT];
   wire aal_addr_s  dec_addr = {is_ind, instr_i[6:4], instr_i[3], instr_i[2:0], instr_i[6:0]};
   wire logic op_add_with_carry_op = (opc == OPC_ADD_WITH_CARRY);
   wire logic op_add_unsigned_op = (opc == OPC_ADD_UNSIGNED);
   wire logic op_add_shift_by_temp_op = (opc == OPC_ADD_SHIFT_TEMP);
   wire logic op_and  = (opc == OPC_AND);
   wire logic op_aux_add_immediate_op = (opc == OPC_AUX_ADD_IMM);
   wire logic known   = op_add_with_carry_op | op_add_unsigned_op | op_add_shift_by_temp_op | op_and | op_aux_add_immediate_op;
   wire logic start   = ce_i && instr_valid_i && (state_r == AAL_IDLE) && known;

   // Operand forms: zero-extended for carry/unsigned add_unsigned_op, sign mode for shifted add
   wire logic [31:0] data_zx   = {16'h0000, data_i};
   wire logic [31:0] data_sx   = {{16{sign_extend_mode_i & data_i[15]}}, data_i};
   wire logic [31:0] data_shft = data_sx << temp_multiplier_reg_i[3:0];
   wire logic [31:0] addend    = op_add_shift_by_temp_op ? data_shft : data_zx;
   wire logic [32:0] raw_sum   = {1'b0, acc_r} + {1'b0, addend} + {32'h0, op_add_with_carry_op & carry_r};
   // Signed overflow: operands' signs agree, result sign differs
   wire logic ovf_det = (acc_r[31] == addend[31]) && (raw_sum[31] != acc_r[31]);
   wire logic [31:0] sat_val  = acc_r[31] ? SAT_NEG : SAT_POS;
   wire logic [31:0] sum_res  = (ovf_det && overflow_mode_i) ? sat_val : raw_sum[31:0];
   wire logic [31:0] and_res  = {16'h0000, acc_r[15:0] & data_i};
   // Aux arithmetic wraps unsigned; immediate is a positive 8-bit value
   wire logic [15:0] aux_sum  = aux_r[aux_pointer_sel_r] + {8'h00, instr_i[7:0]};
   wire logic [CYC_W-1:0] calc_cycles;

   aal_cycle_calc u_cycle_calc (
      .tim_i    (timing_i),
      .cycles_o (calc_cycles)
   );

   always_comb begin
      acc_nxt   = acc_r;
      carry_nxt = carry_r;
      ovf_set   = 1'b0;
      if (op_add_with_carry_op || op_add_unsigned_op || op_add_shift_by_temp_op) begin
         acc_nxt   = sum_res;
         carry_nxt = raw_sum[32];
         ovf_set   = ovf_det && !op_add_shift_by_temp_op;
      end else if (op_and) begin
         acc_nxt = and_res;
      end
   end

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         acc_r             <= ACC_RST;
         carry_r           <= 1'b0;
         ovf_r             <= 1'b0;
         aux_pointer_sel_r <= 3'h0;
         addr_r            <= '0;
         cycles_r          <= '0;
         cnt_r             <= '0;
         done_r            <= 1'b0;
         state_r           <= AAL_IDLE;
      end else if (ce_i) begin
         done_r <= 1'b0;
         unique case (state_r)
            AAL_IDLE: begin
               if (start) begin
                  acc_r    <= acc_nxt;
                  carry_r  <= carry_nxt;
                  // Overflow flag is sticky; only set here, never cleared by these ops
                  ovf_r    <= ovf_r | ovf_set;
                  addr_r   <= dec_addr;
                  cycles_r <= calc_cycles;
                  if (!op_aux_add_immediate_op && is_ind && instr_i[3]) begin
                     aux_pointer_sel_r <= instr_i[2:0];
                  end
                  if (calc_cycles > 16'h0001) begin
                     cnt_r   <= CYC_W'(calc_cycles - 16'h0002);
                     state_r <= AAL_WAIT;
                  end else begin
                     done_r  <= 1'b1;
                  end
               end
            end
            AAL_WAIT: begin
               // Hold for the computed cycle count so the result retires on time
               if (cnt_r == '0) begin
                  done_r  <= 1'b1;
                  state_r <= AAL_IDLE;
               end else begin
                  cnt_r <= CYC_W'(cnt_r - 16'h0001);
               end
            end
         endcase
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_aux
         always_ff @(posedge mclk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
               aux_r[gi] <= AUX_RST;
            end else if (ce_i && start && op_aux_add_immediate_op && (aux_pointer_sel_r == 3'(gi))) begin
               aux_r[gi] <= aux_sum;
            end
         end
      end
   endgenerate

   logic [15:0] aux_out_r;
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         aux_out_r <= AUX_RST;
      end else if (ce_i) begin
         aux_out_r <= (start && op_aux_add_immediate_op) ? aux_sum : aux_r[aux_pointer_sel_r];
      end
   end

   logic busy_r;
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         busy_r <= 1'b0;
      end else if (ce_i) begin
         busy_r <= (state_r == AAL_IDLE) ? (start && calc_cycles > 16'h0001) : (cnt_r != '0);
      end
   end

   assign acc_o               = acc_r;
   assign carry_o             = carry_r;
   assign arith_excess_flag_o = ovf_r;
   assign aux_pointer_sel_o   = aux_pointer_sel_r;
   assign aux_reg_o           = aux_out_r;
   assign addr_o              = addr_r;
   assign cycles_o            = cycles_r;
   assign done_o              = done_r;
   assign busy_o              = busy_r;
endmodule : aal_datapath

// *** rtl/aal_pkg.sv ***
// Constants, opcodes and carriers for the accumulator add/logic datapath.
// Assumes one synchronous clock domain; instruction words arrive already fetched.
// What this block does
// - Add-with-carry add_unsigned_op unsigned data word plus carry to the 32-bit sum.
// - Add-with-carry sets carry on carry out, clears it otherwise.
// - Add-with-carry ignores sign mode, obeys overflow mode, updates carry and overflow.
// - Opcode in bits 15:8; bit 7 low means direct, low 7 bits offset.
// - Bit 7 high means indirect: update field, pointer-change flag, next register.
// - Aux add-immediate add_unsigned_op 8-bit immediate to aux register chosen by pointer.
// - Aux arithmetic is unsigned, immediate positive, no status flags change.
// - Single add: 1 cycle internal, 1+d, 1+p, or 2+d+p external.
// - Operand and code in same single-access block: 2 instead of 1, n+1.
// - Repeated add: n, n+nd external operand, n+1+p+nd both external.
// - Short immediate add takes 1 cycle, or 1+p from external code.
// - Long immediate add takes 2 cycles, or 2+2p from external code.
package aal_pkg;
   localparam logic [7:0] OPC_ADD_WITH_CARRY = 8'h60;
   localparam logic [7:0] OPC_ADD_UNSIGNED   = 8'h62;
   localparam logic [7:0] OPC_ADD_SHIFT_TEMP = 8'h63;
   localparam logic [7:0] OPC_AND            = 8'h6e;
   localparam logic [7:0] OPC_AUX_ADD_IMM    = 8'h78;
   localparam int         IND_BIT            = 7;
   localparam int         CYC_W              = 16;
   localparam logic [31:0] ACC_RST           = 32'h0000_0000;
   localparam logic [15:0] AUX_RST           = 16'h0000;
   localparam logic [31:0] SAT_POS           = 32'h7fff_ffff;
   localparam logic [31:0] SAT_NEG           = 32'h8000_0000;

   typedef enum logic [1:0] {
      AAL_LOC_ROM,
      AAL_LOC_DUAL_ACCESS_RAM,
      AAL_LOC_SINGLE_ACCESS_RAM,
      AAL_LOC_EXT
   } aal_loc_e;

   typedef enum logic [1:0] {
      AAL_FORM_MEM,
      AAL_FORM_SHORT,
      AAL_FORM_LONG
   } aal_form_e;

   // Placement of code/operand and wait figures used by the cycle counter
   typedef struct packed {
      aal_form_e  form;
      aal_loc_e   code_loc;
      aal_loc_e   opnd_loc;
      logic       same_block;
      logic       repeated;
      logic [7:0] rpt_n;
      logic [3:0] wait_p;
      logic [3:0] wait_d;
   } aal_timing_s;

   typedef struct packed {
      logic       indirect;
      logic [2:0] aux_update_field;
      logic       aux_change;
      logic [2:0] next_aux_field;
      logic [6:0] dma;
   } aal_addr_s;
endpackage : aal_pkg

// *** sim/aal_datapath_monitor.sv ***
// Concurrent checks on the add/logic datapath ports.
// Assumes one clock domain and that a request is taken only while busy_o is low.
`timescale 1ns/1ps
module aal_datapath_monitor
   import aal_pkg::*;
(
   input wire logic              mclk_i, reset_n_i, ce_i, instr_valid_i,
   input wire logic [15:0]       instr_i, data_i, temp_multiplier_reg_i,
   input wire logic              sign_extend_mode_i, overflow_mode_i,
   input wire aal_timing_s       timing_i,
   input wire logic [31:0]       acc_o,
   input wire logic              carry_o, arith_excess_flag_o,
   input wire logic [2:0]        aux_pointer_sel_o,
   input wire logic [15:0]       aux_reg_o,
   input wire aal_addr_s         addr_o,
   input wire logic [CYC_W-1:0]  cycles_o,
   input wire logic              done_o, busy_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);
   wire       tk  = ce_i && instr_valid_i && !busy_o;
   wire [7:0] op  = instr_i[15:8];
   wire       mem = op == OPC_ADD_WITH_CARRY || op == OPC_ADD_UNSIGNED || op == OPC_ADD_SHIFT_TEMP || op == OPC_AND;
   property p_add_with_carry_op; tk && op == OPC_ADD_WITH_CARRY && !overflow_mode_i |=>
      {carry_o, acc_o} == {1'b0, $past(acc_o)} + 33'($past(data_i)) + 33'($past(carry_o)); endproperty
   a_add_with_carry_op: assert property (p_add_with_carry_op) else $error("add with carry sum or carry wrong");
   property p_add_unsigned_op; tk && op == OPC_ADD_UNSIGNED && !overflow_mode_i |=>
      {carry_o, acc_o} == {1'b0, $past(acc_o)} + 33'($past(data_i)); endproperty
   a_add_unsigned_op: assert property (p_add_unsigned_op) else $error("unsigned add sum or carry wrong");
   property p_shift; tk && op == OPC_ADD_SHIFT_TEMP && !sign_extend_mode_i && !overflow_mode_i |=>
      acc_o == $past(acc_o) + (32'($past(data_i)) << ($past(temp_multiplier_reg_i) & 16'h000f)); endproperty
   a_shift: assert property (p_shift) else $error("shifted add sum wrong");
   property p_and; tk && op == OPC_AND |=> acc_o == ($past(acc_o) & {16'h0000, $past(data_i)})
      && $stable(carry_o) && $stable(arith_excess_flag_o); endproperty
   a_and: assert property (p_and) else $error("conjunction result or flags wrong");
   property p_aux_add_immediate_op; tk && op == OPC_AUX_ADD_IMM |=> aux_reg_o == $past(aux_reg_o) + ($past(instr_i) & 16'h00ff)
      && $stable(carry_o) && $stable(acc_o) && $stable(arith_excess_flag_o); endproperty
   a_aux_add_immediate_op: assert property (p_aux_add_immediate_op) else $error("aux add immediate wrong");
   property p_direct; tk && mem && !instr_i[IND_BIT] |=>
      !addr_o.indirect && 16'(addr_o.dma) == ($past(instr_i) & 16'h007f); endproperty
   a_direct: assert property (p_direct) else $error("direct offset decode wrong");
   property p_ind; tk && mem && instr_i[IND_BIT] && instr_i[3] |=> addr_o.indirect
      && aux_pointer_sel_o == 3'($past(instr_i)) && addr_o.aux_update_field == 3'($past(instr_i) >> 4); endproperty
   a_ind: assert property (p_ind) else $error("indirect field decode wrong");
   property p_single; tk && mem && timing_i.form == AAL_FORM_MEM && timing_i.code_loc == AAL_LOC_ROM
      && timing_i.opnd_loc == AAL_LOC_DUAL_ACCESS_RAM && !timing_i.repeated |=> done_o && cycles_o == 16'h0001; endproperty
   a_single: assert property (p_single) else $error("single internal add not one cycle");
   property p_busy; tk && mem && timing_i.form == AAL_FORM_MEM && timing_i.code_loc == AAL_LOC_ROM
      && timing_i.opnd_loc == AAL_LOC_EXT && !timing_i.repeated && timing_i.wait_d == 4'h2
      |=> (busy_o && !done_o) ##1 (busy_o && !done_o) ##1 (!busy_o && done_o); endproperty
   a_busy: assert property (p_busy) else $error("busy or done timing wrong for external operand");
endmodule : aal_datapath_monitor

bind aal_datapath aal_datapath_monitor i_aal_datapath_monitor (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
   .ce_i(ce_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i), .data_i(data_i),
   .temp_multiplier_reg_i(temp_multiplier_reg_i), .sign_extend_mode_i(sign_extend_mode_i),
   .overflow_mode_i(overflow_mode_i), .timing_i(timing_i), .acc_o(acc_o), .carry_o(carry_o),
   .arith_excess_flag_o(arith_excess_flag_o), .aux_pointer_sel_o(aux_pointer_sel_o), .aux_reg_o(aux_reg_o),
   .addr_o(addr_o), .cycles_o(cycles_o), .done_o(done_o), .busy_o(busy_o));

// *** sim/aal_mem_model.sv ***
// Program and data memory seen by the datapath: instruction word plus operand.
// Assumes the reader settles the address a half cycle before the taking edge.
`timescale 1ns/1ps
module aal_mem_model (
   input  wire logic [3:0]  pc_i,
   output logic [15:0]      instr_o,
   output logic [15:0]      data_o
);
   always_comb begin
      case (pc_i)
         4'h0: {instr_o, data_o} = {16'h6301, 16'hffff};
         4'h1: {instr_o, data_o} = {16'h6002, 16'h7fff};
         4'h2: {instr_o, data_o} = {16'h60a9, 16'h0001};
         4'h3: {instr_o, data_o} = {16'h6003, 16'h0005};
         4'h4: {instr_o, data_o} = {16'h6204, 16'hffff};
         4'h5: {instr_o, data_o} = {16'h6305, 16'h0001};
         4'h6: {instr_o, data_o} = {16'h6e06, 16'h00ff};
         4'h8: {instr_o, data_o} = {16'h6000, 16'h0000};
         4'h7, 4'h9: {instr_o, data_o} = {16'h78ff, 16'ha5a5};
         // Words that drive the sum register into saturation
         4'ha: {instr_o, data_o} = {16'h630a, 16'h7fff};
         4'hb: {instr_o, data_o} = {16'h620b, 16'h0001};
         // Empty words read as an unknown opcode, ignored by the block
         default: {instr_o, data_o} = {16'h0000, ~pc_i, 12'h5a5};
      endcase
   end
endmodule : aal_mem_model

// *** sim/tb.sv ***
// Self-checking bench: runs a short program, then a table of placement cases.
// Assumes inputs change at the falling edge and one instruction in flight.
`timescale 1ns/1ps
module tb;
   import aal_pkg::*;
   logic mclk_i = 0, reset_n_i = 0, vld = 0, sign_extend_mode = 0, ce = 1, overflow_mode = 0;
   logic [3:0]  pc = 4'h0;
   aal_timing_s tim = '0, tc [9];
   wire [15:0]  m_instr, m_data, aux_reg, cyc;
   wire [31:0]  acc;
   wire         carry, ovf, done, busy;
   wire [2:0]   ptr;
   aal_addr_s   addr;
   int          bad_count = 0, total_checks = 0, lat;
   localparam logic [31:0] EXP_ACC [8] = '{32'hffff8000, 32'hffffffff, 32'h0, 32'h6, 32'h10005, 32'h18005, 32'h5, 32'h5};
   localparam int EC [9] = '{1, 3, 7, 2, 4, 11, 3, 6, 5};
   localparam logic [31:0] EXP_SAT [3] = '{32'h3fff8005, 32'h7fff0005, 32'h7fffffff};
   always #2.5 mclk_i = ~mclk_i;
   aal_mem_model i_aal_mem_model (.pc_i(pc), .instr_o(m_instr), .data_o(m_data));
   aal_datapath i_aal_datapath (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .ce_i(ce), .instr_valid_i(vld),
      .instr_i(m_instr), .data_i(m_data), .temp_multiplier_reg_i(16'h000f), .sign_extend_mode_i(sign_extend_mode),
      .overflow_mode_i(overflow_mode), .timing_i(tim), .acc_o(acc), .carry_o(carry), .arith_excess_flag_o(ovf),
      .aux_pointer_sel_o(ptr), .aux_reg_o(aux_reg), .addr_o(addr), .cycles_o(cyc), .done_o(done), .busy_o(busy));
   // Wide enough for flag and sum register compared together
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : complete_run
   // Bounded wait: a lost done pulse ends the run instead of hanging
   task automatic exec(input logic [3:0] p, input aal_timing_s t, output int n);
      @(negedge mclk_i);
      pc = p; tim = t; vld = 1;
      @(negedge mclk_i);
      vld = 0;
      n = 1;
      while (done !== 1'b1 && n < 400) begin
         @(negedge mclk_i);
         n++;
      end
      if (n >= 400) begin
         bad_count++;
         complete_run();
      end
   endtask : exec
   function automatic aal_timing_s tmk(input aal_form_e f, input aal_loc_e c, o, input logic s, r,
                                        input logic [7:0] n, input logic [3:0] p, d);
      tmk = '{f, c, o, s, r, n, p, d};
   endfunction : tmk
   initial begin
      tc[0] = tmk(AAL_FORM_MEM, AAL_LOC_ROM, AAL_LOC_DUAL_ACCESS_RAM, 0, 0, 0, 0, 0);
      tc[1] = tmk(AAL_FORM_MEM, AAL_LOC_ROM, AAL_LOC_EXT, 0, 0, 0, 0, 2);
      tc[2] = tmk(AAL_FORM_MEM, AAL_LOC_EXT, AAL_LOC_EXT, 0, 0, 0, 3, 2);
      tc[3] = tmk(AAL_FORM_MEM, AAL_LOC_SINGLE_ACCESS_RAM, AAL_LOC_SINGLE_ACCESS_RAM, 1, 0, 0, 0, 0);
      tc[4] = tmk(AAL_FORM_MEM, AAL_LOC_ROM, AAL_LOC_DUAL_ACCESS_RAM, 0, 1, 4, 0, 0);
      tc[5] = tmk(AAL_FORM_MEM, AAL_LOC_EXT, AAL_LOC_EXT, 0, 1, 3, 1, 2);
      tc[6] = tmk(AAL_FORM_SHORT, AAL_LOC_EXT, AAL_LOC_ROM, 0, 0, 0, 2, 0);
      tc[7] = tmk(AAL_FORM_LONG, AAL_LOC_EXT, AAL_LOC_ROM, 0, 0, 0, 2, 0);
      tc[8] = tmk(AAL_FORM_MEM, AAL_LOC_SINGLE_ACCESS_RAM, AAL_LOC_SINGLE_ACCESS_RAM, 1, 1, 4, 0, 0);
      repeat (3) @(posedge mclk_i);
      @(negedge mclk_i) reset_n_i = 1;
      check(acc, 32'h0);
      for (int i = 0; i < 8; i++) begin
         sign_extend_mode = (i == 0);
         exec(4'(i), tc[0], lat);
         check({carry, acc}, {(i == 2), EXP_ACC[i]});
         if (i == 2) check({addr.indirect, addr.aux_update_field, ptr}, 7'b1010001);
         if (i == 6) check(addr.dma, 7'h06);
      end
      check(aux_reg, 16'h00ff);
      exec(4'h9, tc[0], lat);
      check({ovf, carry, acc, aux_reg}, {2'b00, 32'h5, 16'h01fe});
      for (int j = 0; j < 9; j++) begin
         exec(4'h8, tc[j], lat);
         check({cyc, 16'(lat)}, {16'(EC[j]), 16'(EC[j])});
      end
      // Clock enable low: a standing request is neither taken nor retired
      @(negedge mclk_i);
      ce = 0;
      pc = 4'hb;
      vld = 1;
      repeat (3) @(negedge mclk_i);
      check({done, busy, acc}, {2'b00, 32'h5});
      vld = 0;
      ce = 1;
      // Overflow mode: shifted add_unsigned_op climb to the positive limit, then clamp
      overflow_mode = 1;
      for (int k = 0; k < 3; k++) begin
         exec(4'ha, tc[0], lat);
         check({carry, acc}, {1'b0, EXP_SAT[k]});
      end
      exec(4'hb, tc[0], lat);
      check({ovf, carry, acc}, {2'b10, 32'h7fffffff});
      exec(4'h1, tc[0], lat);
      check({ovf, carry, acc}, {2'b10, 32'h7fffffff});
      overflow_mode = 0;
      complete_run();
   end
endmodule : tb
